/* power_mode_pkg.sv */
package power_mode_pkg;

  // Register byte addresses
  localparam logic [7:0] PowerControlIdx  = 8'h87;
  localparam logic [11:0] PowerControlAddr = {2'b00, PowerControlIdx, 2'b00};
  localparam logic [11:0] ResetSourceAddr  = 12'h100;
  localparam logic [11:0] CoreStatusAddr   = 12'h104;
  localparam logic [11:0] SupplyCtrlAddr   = 12'h108;

  // Power control fields
  localparam int          IdleBit       = 0;
  localparam int          StopBit       = 1;
  localparam int          FlagsLsb      = 2;
  localparam logic [7:0]  PowerCtrlRst  = 8'h00;
  localparam logic [5:0]  FlagsRst      = 6'h00;

  // Reset source fields
  localparam int          PinFlagBit    = 0;
  localparam int          PorFlagBit    = 1;
  localparam int          ClkDetBit     = 2;
  localparam int          WdogFlagBit   = 3;
  localparam int          SwResetBit    = 4;

  // Core side constants
  localparam logic [15:0] ResetVector   = 16'h0000;
  localparam logic [7:0]  PortLatchRst  = 8'hFF;
  localparam int          WdogDivide    = 12;
  localparam logic [3:0]  WdogDivLast   = 4'(WdogDivide - 1);

  // Timing
  localparam int          ClockMhz      = 250;
  localparam int          PorDelayUs10  = 3;  // 0.3 ms in units of 100 us
  localparam int          PorDelayCyc   = PorDelayUs10 * 100 * ClockMhz;
  localparam int          ClkDetUs      = 100;
  localparam int          ClkDetCyc     = ClkDetUs * ClockMhz;
  localparam int          SyncStages    = 3;

  typedef enum logic [3:0] {
    StHold = 4'b0001,
    StRun  = 4'b0010,
    StIdle = 4'b0100,
    StStop = 4'b1000
  } mode_t;

endpackage

/* reset_delay_counter.sv */
`timescale 1ns/1ns
module reset_delay_counter #(
  parameter int Cycles = 75000
) (
  input  wire logic sys_clk,
  input  wire logic restart,
  output logic      done
);
  import power_mode_pkg::*;

  typedef struct packed {
    logic [23:0] count;
    logic        done;
  } cnt_t;

  cnt_t state;
  cnt_t next_state;

  always_comb begin
    next_state = state;
    if (restart) begin
      next_state.count = 24'h00_0000;
      next_state.done  = 1'b0;
    end else if (!state.done) begin
      if (state.count >= 24'(Cycles - 1)) begin
        next_state.done = 1'b1;
      end else begin
        next_state.count = state.count + 24'h00_0001;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    state <= next_state;
  end

  assign done = state.done;
endmodule

/* power_mode_reset_control.sv */
// Our own choice: the AXI4-Lite slave port.
`timescale 1ns/1ns
// Contract
// - Idle request bit halts core after the setting write completes.
// - Idle keeps registers, memory, clocks and peripherals running.
// - Enabled interrupt or any reset ends idle; interrupt clears idle bit.
// - Interrupt wake resumes core at instruction after the idle request.
// - Reset out of idle or stop restarts core at address zero.
// - Enabled watchdog keeps counting in idle and may reset device.
// - Stop request halts oscillator, core, digital peripherals; not crystal.
// - Stop ignores interrupts; only resets wake it.
// - Clock detector stays active in stop and resets if enabled.
// - Idle and stop request bits always read zero.
// - Upper six bits are plain read/write flags, reset zero.
// - Reset halts core, resets registers, fixes ports, disables timers.
// - Reset keeps data memory; only stack pointer reinitialised.
// - Port latches forced to ones, open-drain, weak pullups on.
// - Supply and power-on resets drive reset pin low while held.
// - Leaving reset clears program counter, selects internal oscillator.
// - Leaving reset enables watchdog clocked at system clock / 12.
// - Power-up holds reset until supply good, then adds release delay.
// - Power-on exit sets power-on flag to one.
// - Every other reset clears the power-on flag.
// - Power-on reset leaves the supply monitor disabled.
module power_mode_reset_control #(
  parameter int PorCycles    = power_mode_pkg::PorDelayCyc,
  parameter int ClkDetCycles = power_mode_pkg::ClkDetCyc
) (
  input  wire logic        sys_clk,
  input  wire logic        srst,
  // AXI4-Lite slave
  input  wire logic [11:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [11:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Core side
  input  wire logic        instrDone,
  input  wire logic        irqPending,
  input  wire logic        wdogExpired,
  input  wire logic        otherReset,
  output logic             coreHalt,
  output logic             coreReset,
  output logic             clearIdleOnWake,
  output logic [15:0]      resetVector,
  output logic             intOscSelect,
  output logic             intOscRun,
  output logic             digitalClockRun,
  output logic             wdogEnable,
  output logic             wdogTick,
  output logic [7:0]       portLatch,
  output logic             portOpenDrain,
  output logic             weakPullupEn,
  output logic             clearStackPointer,
  // Supply and pins
  input  wire logic        supplyGood,
  input  wire logic        extResetPin,
  input  wire logic        clockAlive,
  output logic             resetPinOut,
  output logic             resetPinOe,
  output logic             supplyMonitorEn
);
  import power_mode_pkg::*;

  typedef struct packed {
    mode_t       mode;
    logic [5:0]  general_purpose_flags;
    logic        pendIdle;
    logic        pendStop;
    logic        power_on_reset_flag;
    logic        pinFlag;
    logic        clkDetFlag;
    logic        wdogFlag;
    logic        swFlag;
    logic        swSrcFlag;
    logic        clkDetEnable;
    logic        monitorEn;
    logic        wdogOn;
    logic        porHold;
    logic        pinHold;
    logic [2:0]  supSync;
    logic [2:0]  pinSync;
    logic [2:0]  aliveSync;
    logic [3:0]  divCnt;
    logic [23:0] deadCnt;
    logic        awTaken;
    logic        wTaken;
    logic [11:0] awAddr;
    logic [31:0] wData;
    logic [3:0]  wStrb;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } state_t;

  state_t state;
  state_t next_state;
  logic   porDelayDone;
  logic   restartDelay;
  logic   anyReset;
  logic   doWrite;

  function automatic logic mapped(input logic [11:0] a);
    return a == PowerControlAddr || a == ResetSourceAddr ||
           a == CoreStatusAddr || a == SupplyCtrlAddr;
  endfunction

  // Pin level counts once stages two and three agree
  function automatic logic settledHigh(input logic [2:0] s);
    return s[1] && s[2];
  endfunction

  function automatic logic settledLow(input logic [2:0] s);
    return !s[1] && !s[2];
  endfunction

  reset_delay_counter #(.Cycles(PorCycles)) u_delay (
    .sys_clk (sys_clk),
    .restart (restartDelay),
    .done    (porDelayDone)
  );

  assign restartDelay = srst || !settledHigh(state.supSync);
  assign doWrite = state.awTaken && state.wTaken && !state.bvalid;

  always_comb begin
    logic supOk;
    logic pinLow;
    logic clkDead;
    logic [31:0] rd;
    next_state = state;
    supOk   = settledHigh(state.supSync);
    pinLow  = settledLow(state.pinSync);
    clkDead = state.deadCnt >= 24'(ClkDetCycles);
    rd      = 32'h0000_0000;
    next_state.supSync   = {state.supSync[1:0], supplyGood};
    next_state.pinSync   = {state.pinSync[1:0], extResetPin};
    next_state.aliveSync = {state.aliveSync[1:0], clockAlive};
    anyReset = 1'b0;

    // clock detector counts while stopped too
    if (state.aliveSync[1] != state.aliveSync[2] || !state.clkDetEnable) begin
      next_state.deadCnt = 24'h00_0000;
    end else if (!clkDead) begin
      next_state.deadCnt = state.deadCnt + 24'h00_0001;
    end

    if (state.wdogOn && state.mode != StStop) begin
      next_state.divCnt = (state.divCnt == WdogDivLast) ? 4'h0
                          : state.divCnt + 4'h1;
    end

    // AXI channels
    if (s_axi_awvalid && !state.awTaken) begin
      next_state.awTaken = 1'b1;
      next_state.awAddr  = s_axi_awaddr;
    end
    if (s_axi_wvalid && !state.wTaken) begin
      next_state.wTaken = 1'b1;
      next_state.wData  = s_axi_wdata;
      next_state.wStrb  = s_axi_wstrb;
    end
    if (doWrite) begin
      next_state.bvalid  = 1'b1;
      next_state.bresp   = mapped(state.awAddr) ? 2'b00 : 2'b10;
      next_state.awTaken = 1'b0;
      next_state.wTaken  = 1'b0;
      if (state.wStrb[0] && state.mode == StRun) begin
        unique case (state.awAddr)
          PowerControlAddr: begin
            next_state.general_purpose_flags = state.wData[7:FlagsLsb];
            next_state.pendStop = state.wData[StopBit];
            next_state.pendIdle = state.wData[IdleBit]
                                  && !state.wData[StopBit];
          end
          ResetSourceAddr: begin
            next_state.clkDetEnable = state.wData[ClkDetBit];
            next_state.swFlag = state.wData[SwResetBit];
          end
          SupplyCtrlAddr: next_state.monitorEn = state.wData[0];
          default: ;
        endcase
      end
    end
    if (state.bvalid && s_axi_bready) begin
      next_state.bvalid = 1'b0;
    end
    if (s_axi_arvalid && !state.rvalid) begin
      unique case (s_axi_araddr)
        PowerControlAddr: rd = {24'h00_0000, state.general_purpose_flags,
                                2'b00};
        ResetSourceAddr: rd = {27'h000_0000, state.swSrcFlag,
                               state.wdogFlag, state.clkDetFlag,
                               state.power_on_reset_flag, state.pinFlag};
        CoreStatusAddr: rd = {28'h000_0000, state.mode};
        SupplyCtrlAddr: rd = {31'h0000_0000, state.monitorEn};
        default: rd = 32'h0000_0000;
      endcase
      next_state.rvalid = 1'b1;
      next_state.rdata  = rd;
      next_state.rresp  = mapped(s_axi_araddr) ? 2'b00 : 2'b10;
    end
    if (state.rvalid && s_axi_rready) begin
      next_state.rvalid = 1'b0;
    end

    // Power mode sequencing
    unique case (state.mode)
      StHold: begin
        // release once every hold source is gone
        if (!state.porHold && !state.pinHold) begin
          next_state.mode = StRun;
        end
      end
      StRun: begin
        // enter after the setting instruction retires
        if (state.pendStop && instrDone) begin
          next_state.mode = StStop;
          next_state.pendStop = 1'b0;
        end else if (state.pendIdle && instrDone) begin
          next_state.mode = StIdle;
        end
      end
      StIdle: begin
        // enabled interrupt wakes and clears request
        if (irqPending) begin
          next_state.mode = StRun;
          next_state.pendIdle = 1'b0;
        end
      end
      StStop: begin
        next_state.mode = StStop;
      end
    endcase

    // Reset sources
    if (!supOk) begin
      next_state.porHold = 1'b1;
      next_state.monitorEn = 1'b0;
      anyReset = 1'b1;
    end else if (state.porHold && porDelayDone) begin
      next_state.porHold = 1'b0;
      next_state.power_on_reset_flag = 1'b1;
    end
    next_state.pinHold = pinLow;
    if (pinLow || (clkDead && state.clkDetEnable) || wdogExpired ||
        otherReset || state.swFlag) begin
      if (supOk && !state.porHold) begin
        next_state.power_on_reset_flag = 1'b0;
        next_state.pinFlag    = pinLow;
        next_state.clkDetFlag = clkDead && state.clkDetEnable;
        next_state.wdogFlag   = wdogExpired;
        next_state.swSrcFlag  = state.swFlag;
      end
      anyReset = 1'b1;
      next_state.swFlag = 1'b0;
    end
    if (anyReset) begin
      // flags, idle/stop requests and watchdog back to defaults (clock detector enable kept; supply monitor enable kept except on supply loss), core held
      // reset exits idle or stop through hold
      next_state.mode = StHold;
      next_state.general_purpose_flags = FlagsRst;
      next_state.pendIdle = 1'b0;
      next_state.pendStop = 1'b0;
      next_state.wdogOn = 1'b1;
      next_state.divCnt = 4'h0;
      next_state.deadCnt = 24'h00_0000;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      state <= '0;
      state.mode <= StHold;
      state.porHold <= 1'b1;
      state.wdogOn <= 1'b1;
      state.general_purpose_flags <= FlagsRst;
    end else begin
      state <= next_state;
    end
  end

  assign s_axi_awready = !state.awTaken;
  assign s_axi_wready  = !state.wTaken;
  assign s_axi_bvalid  = state.bvalid;
  assign s_axi_bresp   = state.bresp;
  assign s_axi_arready = !state.rvalid;
  assign s_axi_rvalid  = state.rvalid;
  assign s_axi_rdata   = state.rdata;
  assign s_axi_rresp   = state.rresp;

  assign coreHalt        = state.mode != StRun;
  assign coreReset       = state.mode == StHold;
  // core resumes in place after the interrupt
  assign clearIdleOnWake = state.mode == StIdle && irqPending;
  assign resetVector     = ResetVector;
  assign intOscSelect    = state.mode == StHold;
  // stop halts oscillator and digital clocks
  assign intOscRun       = state.mode != StStop;
  assign digitalClockRun = state.mode != StStop;
  assign wdogEnable      = state.wdogOn;
  // divider frozen in stop, so no tick
  assign wdogTick        = state.wdogOn && state.mode != StStop &&
                           state.divCnt == WdogDivLast;
  assign portLatch       = PortLatchRst;
  assign portOpenDrain   = state.mode == StHold;
  assign weakPullupEn    = 1'b1;
  assign clearStackPointer = state.mode == StHold;
  // pin driven low only for supply resets
  assign resetPinOe      = state.porHold;
  assign resetPinOut     = 1'b0;
  assign supplyMonitorEn = state.monitorEn;
endmodule

/* power_mode_monitor.sv */
`timescale 1ns/1ns
module power_mode_monitor (
  input wire logic       sys_clk,
  input wire logic       srst,
  input wire logic       irqPending,
  input wire logic       coreHalt,
  input wire logic       coreReset,
  input wire logic       clearIdleOnWake,
  input wire logic       intOscSelect,
  input wire logic       intOscRun,
  input wire logic       digitalClockRun,
  input wire logic       wdogTick,
  input wire logic [7:0] portLatch,
  input wire logic       portOpenDrain,
  input wire logic       weakPullupEn,
  input wire logic       clearStackPointer,
  input wire logic       resetPinOut,
  input wire logic       resetPinOe
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst);
  sequence holdSeq;
    coreHalt && clearStackPointer && intOscSelect;
  endsequence
  sequence stayStopped;
    !clearIdleOnWake ##1 (!intOscRun || coreReset);
  endsequence
  sequence tickGap;
    !wdogTick [*8];
  endsequence
  a_hold_core: assert property (coreReset |-> holdSeq)
    else $error("core not held in reset");
  a_port_safe: assert property (coreReset |-> portLatch == 8'hFF
    && portOpenDrain && weakPullupEn) else $error("ports not safe");
  a_pin_low: assert property (resetPinOe |-> !resetPinOut && coreReset)
    else $error("reset pin not low");
  a_stop_halt: assert property (!intOscRun |-> coreHalt
    && !digitalClockRun) else $error("stop left clocks on");
  a_stop_deaf: assert property (!intOscRun |-> stayStopped)
    else $error("stop woke on interrupt");
  a_wake_clear: assert property (clearIdleOnWake |-> irqPending
    && coreHalt && !coreReset) else $error("bad idle wake");
  a_tick_gap: assert property (wdogTick |=> tickGap)
    else $error("tick too soon");
  a_idle_awake: assert property (coreHalt && !coreReset
    && intOscRun |-> digitalClockRun) else $error("idle stopped clocks");
endmodule

bind power_mode_reset_control power_mode_monitor mon_u (.*);

/* core_model.sv */
`timescale 1ns/1ns
module core_model (
  input wire logic sys_clk,
  input wire logic coreHalt,
  output logic     instrDone
);
  initial instrDone = 1'h0;
  always @(posedge sys_clk) instrDone <= !coreHalt && !instrDone;
endmodule

/* tb_power_mode_reset_control.sv */
`timescale 1ns/1ns
module tb_power_mode_reset_control;
  import power_mode_pkg::*;
  logic        sys_clk = 1'h0;
  logic        srst = 1'h1;
  logic [11:0] s_axi_awaddr = 12'h0, s_axi_araddr = 12'h0;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, d;
  logic [3:0]  s_axi_wstrb = 4'h1;
  logic        s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0;
  logic        s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic        s_axi_bready = 1'h0, irqPending = 1'h0;
  logic        wdogExpired = 1'h0, otherReset = 1'h0;
  logic        supplyGood = 1'h0, extResetPin = 1'h1;
  logic        clockAlive = 1'h0, clkRun = 1'h1;
  logic        instrDone, s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic        s_axi_arready, s_axi_rvalid, coreHalt, coreReset;
  logic        clearIdleOnWake, intOscSelect, intOscRun, digitalClockRun;
  logic        wdogEnable, wdogTick, portOpenDrain, weakPullupEn;
  logic        clearStackPointer, resetPinOut, resetPinOe, supplyMonitorEn;
  logic [1:0]  s_axi_bresp, s_axi_rresp, r, b;
  logic [15:0] resetVector, seed;
  logic [7:0]  portLatch;
  int          errors = 0, compares = 0, flags, ticks;

  always #2 sys_clk = ~sys_clk;
  // Far-side clock pulse, frozen when clkRun drops
  always @(posedge sys_clk) clockAlive <= clkRun ? !clockAlive : clockAlive;

  power_mode_reset_control #(.PorCycles(20), .ClkDetCycles(50)) dut_u (.*);
  core_model core_u (.sys_clk(sys_clk), .coreHalt(coreHalt),
                     .instrDone(instrDone));

  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  task automatic report_and_stop();
    $display("errors=%0d compares=%0d", errors, compares);
    if (errors == 0 && compares > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  task automatic tmo();
    errors++;
    report_and_stop();
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e) begin
      errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] v);
    int n;
    n = 0;
    @(posedge sys_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    while (!(s_axi_bvalid && !s_axi_awvalid && !s_axi_wvalid) && n < 100) begin
      @(posedge sys_clk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'h0;
      n++;
    end
    b = s_axi_bresp;
    s_axi_bready <= 1'h0;
    if (n >= 100) tmo();
  endtask

  task automatic rd(input logic [11:0] a);
    int n;
    n = 0;
    @(posedge sys_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    while (!(s_axi_rvalid && !s_axi_arvalid) && n < 100) begin
      @(posedge sys_clk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'h0;
      n++;
    end
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'h0;
    if (n >= 100) tmo();
  endtask

  task automatic waitMode(input logic [31:0] m);
    int n;
    n = 0;
    do begin
      rd(CoreStatusAddr);
      n++;
    end while (d !== m && n < 300);
    chk(d, m);
    if (n >= 300) tmo();
  endtask

  initial begin
    seed = 16'h4AA8;
    repeat (2) @(posedge sys_clk);
    srst <= 1'h0;
    repeat (30) @(posedge sys_clk);
    rd(CoreStatusAddr);
    chk(d, 32'h1);
    chk(32'(resetPinOe), 32'h1);
    @(posedge sys_clk);
    supplyGood <= 1'h1;
    waitMode(32'h2);
    rd(ResetSourceAddr);
    chk(32'(d[PorFlagBit]), 32'h1);
    chk(32'(supplyMonitorEn), 32'h0);
    chk(32'(wdogEnable), 32'h1);
    chk(32'(resetVector), 32'h0);
    rd(PowerControlAddr);
    chk(d, 32'h0);
    rd(12'h0F0);
    chk(32'(r), 32'h2);
    chk(d, 32'h0);
    wr(12'h0F0, 32'h0);
    chk(32'(b), 32'h2);
    for (int i = 0; i < 4; i++) begin
      seed = lfsr(seed);
      flags = int'(seed[5:0]);
      wr(PowerControlAddr, 32'({seed[5:0], 2'h0}));
      chk(32'(b), 32'h0);
      rd(PowerControlAddr);
      chk(d, 32'(flags << 2));
    end
    wr(PowerControlAddr, 32'(flags << 2 | 1));
    waitMode(32'h4);
    rd(PowerControlAddr);
    chk(d, 32'(flags << 2));
    chk(32'(digitalClockRun), 32'h1);
    ticks = 0;
    repeat (24) begin
      @(posedge sys_clk);
      ticks += int'(wdogTick);
    end
    chk(32'(ticks), 32'h2);
    irqPending <= 1'h1;
    waitMode(32'h2);
    chk(32'(coreHalt), 32'h0);
    irqPending <= 1'h0;
    wr(PowerControlAddr, 32'h0000_00FD);
    waitMode(32'h4);
    wdogExpired <= 1'h1;
    repeat (4) @(posedge sys_clk);
    wdogExpired <= 1'h0;
    waitMode(32'h2);
    rd(ResetSourceAddr);
    chk(32'(d[WdogFlagBit]), 32'h1);
    chk(32'(d[PorFlagBit]), 32'h0);
    rd(PowerControlAddr);
    chk(d, 32'h0);
    wr(PowerControlAddr, 32'h1);
    waitMode(32'h4);
    otherReset <= 1'h1;
    @(posedge sys_clk);
    otherReset <= 1'h0;
    waitMode(32'h2);
    rd(ResetSourceAddr);
    chk(32'(d[WdogFlagBit]), 32'h0);
    wr(PowerControlAddr, 32'h3);
    waitMode(32'h8);
    chk(32'(intOscRun), 32'h0);
    irqPending <= 1'h1;
    repeat (20) @(posedge sys_clk);
    rd(CoreStatusAddr);
    chk(d, 32'h8);
    irqPending <= 1'h0;
    extResetPin <= 1'h0;
    repeat (10) @(posedge sys_clk);
    extResetPin <= 1'h1;
    waitMode(32'h2);
    rd(ResetSourceAddr);
    chk(32'(d[PinFlagBit]), 32'h1);
    wr(SupplyCtrlAddr, 32'h1);
    wr(ResetSourceAddr, 32'(1 << SwResetBit));
    repeat (5) @(posedge sys_clk);
    waitMode(32'h2);
    rd(ResetSourceAddr);
    chk(32'(d[SwResetBit]), 32'h1);
    chk(32'(supplyMonitorEn), 32'h1);
    wr(ResetSourceAddr, 32'(1 << ClkDetBit));
    wr(PowerControlAddr, 32'h2);
    waitMode(32'h8);
    clkRun <= 1'h0;
    repeat (80) @(posedge sys_clk);
    clkRun <= 1'h1;
    waitMode(32'h2);
    rd(ResetSourceAddr);
    chk(32'(d[ClkDetBit]), 32'h1);
    report_and_stop();
  end

  initial begin
    #300000;
    tmo();
  end
endmodule
